// [core/fcdd_core.sv]
`timescale 1ns/100ps
module fcdd_core (
    input  wire logic        i_mclk,        // Clock, 125 MHz.
    input  wire logic        i_rstn,        // Synchronous reset, active low.
    input  wire logic [2:0]  i_copro_id,    // Configured coprocessor identity.
    input  wire logic        i_instr_valid, // Instruction word offered.
    input  wire logic [31:0] i_instr,       // Instruction word.
    input  wire logic        i_data_valid,  // Host data word offered.
    input  wire logic [31:0] i_data,        // Host data word.
    input  wire logic [4:0]  i_rd_addr,     // Register read address.
    output logic             o_ready,       // Idle, instruction taken.
    output logic             o_data_ready,  // Waiting for a host word.
    output logic             o_done,        // Result written, one cycle.
    output logic             o_unknown,     // Foreign code ignored, pulse.
    output logic [63:0]      o_result,      // Last result written.
    output logic [63:0]      o_rd_data      // Register read data.
);
    fcdd_pkg::fcdd_state_type state_r;
    fcdd_pkg::fcdd_state_type state_nxt;
    logic [31:0] ir_r;
    logic [63:0] regs_r [fcdd_pkg::REG_COUNT];
    logic        ready_r, data_ready_r, done_r, unknown_r;
    logic [63:0] result_r, rd_data_r;

    // Pack a double; out-of-range exponents clamp to infinity or zero.
    function automatic logic [63:0] pack_dbl(input logic s, input int ex,
                                              input logic [51:0] f);
        if (ex >= fcdd_pkg::DBL_EXP_MAX) return {s, 11'h7FF, 52'h0};
        if (ex <= 0) return {s, 63'h0};
        return {s, ex[10:0], f};
    endfunction

    // Singles widen exactly; denormals flush to zero.
    function automatic logic [63:0] sgl_to_dbl(input logic [31:0] x);
        if (x[30:23] == 8'h00) return {x[31], 63'h0};
        if (x[30:23] == 8'hFF) return {x[31], 11'h7FF, x[22:0], 29'h0};
        return {x[31], x[30], {3{!x[30]}}, x[29:0], 29'h0};
    endfunction

    // Narrowing truncates toward zero.
    function automatic logic [31:0] dbl_to_sgl(input logic [63:0] x);
        int ex;
        ex = int'(x[62:52]) - fcdd_pkg::DBL_BIAS + 127;
        if (x[62:52] == 11'h7FF) return {x[63], 8'hFF, x[51:29]};
        if (ex >= 255) return {x[63], 8'hFF, 23'h0};
        if (ex <= 0) return {x[63], 31'h0};
        return {x[63], ex[7:0], x[51:29]};
    endfunction

    function automatic logic [63:0] int_to_dbl(input logic [31:0] x);
        logic [31:0] mag;
        logic [63:0] t;
        int          lead;
        mag  = x[31] ? 32'h0 - x : x;
        lead = 0;
        for (int i = 0; i < 32; i++) if (mag[i]) lead = i;
        t = {32'h0, mag} << (63 - lead);
        if (mag == 32'h0) return 64'h0;
        return pack_dbl(x[31], fcdd_pkg::DBL_BIAS + lead, t[62:11]);
    endfunction

    // Alignment of x and 1.0 on the larger exponent with three guard bits, then truncate.
    function automatic logic [63:0] dbl_minus_one(input logic [63:0] x);
        logic [10:0] e, ee;
        logic [57:0] mx, m1, t;
        logic [58:0] v, mag;
        int          lead;
        e  = x[62:52];
        ee = (e > 11'(fcdd_pkg::DBL_BIAS)) ? e : 11'(fcdd_pkg::DBL_BIAS);
        mx = {3'b001, x[51:0], 3'b000} >> (ee - e);
        m1 = {3'b001, 55'h0} >> (ee - 11'(fcdd_pkg::DBL_BIAS));
        v  = (x[63] ? 59'h0 - {1'b0, mx} : {1'b0, mx}) - {1'b0, m1};
        mag  = v[58] ? 59'h0 - v : v;
        lead = 0;
        for (int i = 0; i < 58; i++) if (mag[i]) lead = i;
        t = mag[57:0] << (57 - lead);
        if (e == 11'h000) return fcdd_pkg::DBL_NEG_ONE;
        if (e == 11'h7FF) return x;
        if (mag == 59'h0) return 64'h0;
        return pack_dbl(v[58], int'(ee) + lead - 55, t[56:5]);
    endfunction

    // Field decode works on the offered word when idle, else the held one.
    logic [31:0] cur;
    logic [3:0]  f_src, f_op;
    logic [4:0]  f_dst;
    logic [15:0] f_low;
    logic        f_t, f_s, id_hit, accept;
    logic        is_conv, is_dec_a, is_dec_b, is_div_reg, is_div_host;
    assign cur    = (state_r == fcdd_pkg::S_IDLE) ? i_instr : ir_r;
    assign f_src  = cur[fcdd_pkg::SRC_HI:fcdd_pkg::SRC_LO];
    assign f_op   = cur[fcdd_pkg::OP_HI:fcdd_pkg::OP_LO];
    assign f_dst  = cur[fcdd_pkg::DST_HI:fcdd_pkg::DST_LO];
    assign f_low  = cur[15:0];
    assign f_t    = cur[fcdd_pkg::TYPE_BIT];
    assign f_s    = cur[fcdd_pkg::SIZE_BIT];
    assign id_hit = (cur[fcdd_pkg::ID_HI:fcdd_pkg::ID_LO] == i_copro_id);
    assign accept = (state_r == fcdd_pkg::S_IDLE) && i_instr_valid
                    && id_hit;
    assign is_conv = (f_op == fcdd_pkg::OP_CONVERT)
                     && (f_low == fcdd_pkg::LOW_CONV_HOST
                         || f_low == fcdd_pkg::LOW_CONV_MEM);
    assign is_dec_a = (f_op == fcdd_pkg::OP_MINUS_ONE)
                      && (f_low[15:9] == fcdd_pkg::TOP_DEC_FIRST)
                      && (f_low[6:0] == fcdd_pkg::LOW_TAIL_ZERO);
    assign is_dec_b = (f_op == fcdd_pkg::OP_MINUS_ONE)
                      && (f_low[15:9] == fcdd_pkg::TOP_DEC_SECOND)
                      && (f_low[6:0] == fcdd_pkg::LOW_TAIL_ZERO);
    assign is_div_reg = (f_low[15:9] == fcdd_pkg::TOP_DIV_REG)
                        && (f_low[6:0] == fcdd_pkg::LOW_TAIL_ZERO);
    assign is_div_host = (f_low[15:9] == fcdd_pkg::TOP_DIV_HOST)
                         && (f_low[7:0] == 8'h00);

    // Operand addresses: first bank for converts and dividends, second
    // bank for divisors; minus-one picks its bank from the pattern.
    logic [4:0]  addr_a, addr_b, addr_dec, dec_dst;
    logic [63:0] reg_a, reg_b, reg_dec, dec_val;
    assign addr_a   = {1'b0, f_src};
    assign addr_b   = {1'b1, f_op};
    assign addr_dec = {is_dec_b, f_src};
    assign reg_a    = regs_r[addr_a];
    assign reg_b    = regs_r[addr_b];
    assign reg_dec  = regs_r[addr_dec];
    assign dec_dst  = (f_dst == fcdd_pkg::NO_DEST_CODE) ? addr_dec
                                                        : f_dst;
    assign dec_val  = !f_t ? {32'h0, reg_dec[31:0] - 32'h1}
                    : f_s  ? dbl_minus_one(reg_dec)
                    : {32'h0, dbl_to_sgl(dbl_minus_one(
                          sgl_to_dbl(reg_dec[31:0])))};

    // Divide operands and result shaping; floats divide mantissas.
    logic [63:0]  fa, fb, fq, div_val;
    logic [127:0] div_num, div_quot;
    logic [63:0]  div_den, div_rem;
    logic [31:0]  abs_a, abs_b, iq;
    logic         div_done, div_start, fs;
    assign fa = f_s ? reg_a : sgl_to_dbl(reg_a[31:0]);
    assign fb = f_s ? reg_b : sgl_to_dbl(reg_b[31:0]);
    assign abs_a = reg_a[31] ? 32'h0 - reg_a[31:0] : reg_a[31:0];
    assign abs_b = reg_b[31] ? 32'h0 - reg_b[31:0] : reg_b[31:0];
    assign div_num = f_t ? {20'h0, 1'b1, fa[51:0], 55'h0}
                         : {96'h0, abs_a};
    assign div_den = f_t ? {11'h0, 1'b1, fb[51:0]} : {32'h0, abs_b};
    assign fs = fa[63] ^ fb[63];
    assign fq = (fb[62:52] == 11'h000) ? {fs, 11'h7FF, 52'h0}
              : (fa[62:52] == 11'h000) ? {fs, 63'h0}
              : div_quot[55] ? pack_dbl(fs, int'(fa[62:52])
                    - int'(fb[62:52]) + fcdd_pkg::DBL_BIAS, div_quot[54:3])
              : pack_dbl(fs, int'(fa[62:52]) - int'(fb[62:52])
                    + fcdd_pkg::DBL_BIAS - 1, div_quot[53:2]);
    assign iq = (reg_a[31] ^ reg_b[31]) ? 32'h0 - div_quot[31:0]
                                        : div_quot[31:0];
    assign div_val = !f_t ? {32'h0, iq}
                   : f_s  ? fq : {32'h0, dbl_to_sgl(fq)};
    assign div_start = (state_r == fcdd_pkg::S_DIV_GO);

    fcdd_divider #(
        .NW (fcdd_pkg::DIV_NUM_W),
        .DW (fcdd_pkg::DIV_DEN_W)
    ) u_div (
        .i_mclk  (i_mclk),
        .i_rstn  (i_rstn),
        .i_start (div_start),
        .i_num   (div_num),
        .i_den   (div_den),
        .o_done  (div_done),
        .o_quot  (div_quot),
        .o_rem   (div_rem)
    );

    // Single write port plus the scratch write of an integer divide.
    logic        wr_en, tmp_we, fin;
    logic [4:0]  wr_addr;
    logic [63:0] wr_data;
    logic        take_data;
    assign take_data = i_data_valid && (state_r == fcdd_pkg::S_LOAD_A
                                     || state_r == fcdd_pkg::S_LOAD_B);
    assign tmp_we = (state_r == fcdd_pkg::S_DIV_WAIT) && div_done
                    && !f_t;
    always_comb begin
        wr_en   = 1'b0;
        wr_addr = f_dst;
        wr_data = div_val;
        fin     = 1'b0;
        case (state_r)
            fcdd_pkg::S_IDLE: begin
                wr_en   = accept && (is_dec_a || is_dec_b);
                wr_addr = dec_dst;
                wr_data = dec_val;
                fin     = wr_en;
            end
            fcdd_pkg::S_LOAD_A: begin
                wr_en   = i_data_valid;
                wr_addr = addr_a;
                wr_data = {32'h0, i_data};
            end
            fcdd_pkg::S_LOAD_B: begin
                wr_en   = i_data_valid;
                wr_addr = addr_b;
                wr_data = {32'h0, i_data};
            end
            fcdd_pkg::S_CONV: begin
                wr_en   = 1'b1;
                wr_data = {32'h0,
                    dbl_to_sgl(int_to_dbl(reg_a[31:0]))};
                fin     = 1'b1;
            end
            fcdd_pkg::S_DIV_WAIT: begin
                wr_en = div_done;
                fin   = div_done;
            end
            default: begin
                wr_en = 1'b0;
            end
        endcase
    end

    // Sequencing between host loads, conversion and the divider.
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            fcdd_pkg::S_IDLE: begin
                if (accept && (is_conv || is_div_host))
                    state_nxt = fcdd_pkg::S_LOAD_A;
                else if (accept && is_div_reg)
                    state_nxt = fcdd_pkg::S_DIV_GO;
            end
            fcdd_pkg::S_LOAD_A: begin
                if (i_data_valid)
                    state_nxt = is_conv ? fcdd_pkg::S_CONV
                                        : fcdd_pkg::S_LOAD_B;
            end
            fcdd_pkg::S_LOAD_B: begin
                if (i_data_valid) state_nxt = fcdd_pkg::S_DIV_GO;
            end
            fcdd_pkg::S_CONV:     state_nxt = fcdd_pkg::S_IDLE;
            fcdd_pkg::S_DIV_GO:   state_nxt = fcdd_pkg::S_DIV_WAIT;
            fcdd_pkg::S_DIV_WAIT: begin
                if (div_done) state_nxt = fcdd_pkg::S_IDLE;
            end
            default:              state_nxt = fcdd_pkg::S_IDLE;
        endcase
    end

    // Register file; a named destination wins over the scratch write.
    for (genvar i = 0; i < fcdd_pkg::REG_COUNT; i++) begin : g_reg
        always_ff @(posedge i_mclk) begin
            if (!i_rstn)
                regs_r[i] <= fcdd_pkg::REG_RESET;
            else if (wr_en && wr_addr == 5'(i))
                regs_r[i] <= wr_data;
            else if (tmp_we && fcdd_pkg::TEMP_CODE == 5'(i))
                regs_r[i] <= div_rem;
        end
    end

    // Control and status flops; all outputs come from here.
    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            state_r      <= fcdd_pkg::S_IDLE;
            ir_r         <= 32'h0000_0000;
            ready_r      <= 1'b0;
            data_ready_r <= 1'b0;
            done_r       <= 1'b0;
            unknown_r    <= 1'b0;
            result_r     <= 64'h0000_0000_0000_0000;
            rd_data_r    <= 64'h0000_0000_0000_0000;
        end else begin
            state_r      <= state_nxt;
            ir_r         <= accept ? i_instr : ir_r;
            ready_r      <= (state_nxt == fcdd_pkg::S_IDLE);
            data_ready_r <= (state_nxt == fcdd_pkg::S_LOAD_A
                          || state_nxt == fcdd_pkg::S_LOAD_B);
            done_r       <= fin;
            unknown_r    <= accept && !(is_conv || is_dec_a || is_dec_b
                            || is_div_reg || is_div_host);
            result_r     <= fin ? wr_data : result_r;
            rd_data_r    <= regs_r[i_rd_addr];
        end
    end

    assign o_ready      = ready_r;
    assign o_data_ready = data_ready_r;
    assign o_done       = done_r;
    assign o_unknown    = unknown_r;
    assign o_result     = result_r;
    assign o_rd_data    = rd_data_r;
endmodule

// [core/fcdd_pkg.sv]
package fcdd_pkg;

    // Instruction word field positions.
    localparam int ID_HI  = 31;
    localparam int ID_LO  = 29;
    localparam int SRC_HI = 28;
    localparam int SRC_LO = 25;
    localparam int OP_HI  = 24;
    localparam int OP_LO  = 21;
    localparam int DST_HI = 20;
    localparam int DST_LO = 16;
    localparam int TYPE_BIT = 8;
    localparam int SIZE_BIT = 7;

    // Operation field codes and low half-word patterns.
    localparam logic [3:0]  OP_CONVERT     = 4'h6;
    localparam logic [3:0]  OP_MINUS_ONE   = 4'hD;
    localparam logic [15:0] LOW_CONV_HOST  = 16'h5F00;
    localparam logic [15:0] LOW_CONV_MEM   = 16'h9F00;
    localparam logic [6:0]  TOP_DEC_FIRST  = 7'h01;
    localparam logic [6:0]  TOP_DEC_SECOND = 7'h03;
    localparam logic [6:0]  TOP_DIV_REG    = 7'h09;
    localparam logic [6:0]  TOP_DIV_HOST   = 7'h29;
    localparam logic [6:0]  LOW_TAIL_ZERO  = 7'h00;

    // Register codes: bit 4 selects the second bank.
    localparam logic [4:0]  NO_DEST_CODE = 5'h1D;
    localparam logic [4:0]  SPARE_CODE   = 5'h1E;
    localparam logic [4:0]  TEMP_CODE    = 5'h1F;
    localparam int          REG_COUNT    = 32;
    localparam logic [63:0] REG_RESET    = 64'h0000_0000_0000_0000;

    // Floating-point constants.
    localparam int          DBL_BIAS    = 1023;
    localparam int          DBL_EXP_MAX = 2047;
    localparam logic [63:0] DBL_NEG_ONE = 64'hBFF0_0000_0000_0000;

    // Divider geometry.
    localparam int DIV_NUM_W = 128;
    localparam int DIV_DEN_W = 64;

    typedef enum logic [2:0] {
        S_IDLE     = 3'b000,
        S_LOAD_A   = 3'b001,
        S_LOAD_B   = 3'b010,
        S_CONV     = 3'b011,
        S_DIV_GO   = 3'b100,
        S_DIV_WAIT = 3'b101
    } fcdd_state_type;

endpackage

// [core/fcdd_divider.sv]
`timescale 1ns/100ps
module fcdd_divider #(
    parameter int NW = 128,
    parameter int DW = 64
) (
    input  wire logic          i_mclk,   // Clock.
    input  wire logic          i_rstn,   // Synchronous reset, active low.
    input  wire logic          i_start,  // Start pulse, operands valid.
    input  wire logic [NW-1:0] i_num,    // Unsigned dividend.
    input  wire logic [DW-1:0] i_den,    // Unsigned divisor.
    output logic               o_done,   // One-cycle pulse, result valid.
    output logic [NW-1:0]      o_quot,   // Quotient.
    output logic [DW-1:0]      o_rem     // Remainder.
);
    localparam int CW = $clog2(NW + 1);

    logic [NW-1:0] q_r;
    logic [DW-1:0] rem_r;
    logic [DW-1:0] den_r;
    logic [CW-1:0] cnt_r;
    logic          busy_r;
    logic          done_r;
    logic [DW:0]   shifted;
    logic [DW:0]   trial;
    logic          fits;

    // One restoring step per cycle; a zero divisor yields all ones for a dividend that fits in DW bits.
    assign shifted = {rem_r, q_r[NW-1]};
    assign trial   = shifted - {1'b0, den_r};
    assign fits    = !trial[DW];

    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            q_r    <= '0;
            rem_r  <= '0;
            den_r  <= '0;
            cnt_r  <= '0;
            busy_r <= 1'b0;
            done_r <= 1'b0;
        end else if (i_start && !busy_r) begin
            q_r    <= i_num;
            rem_r  <= '0;
            den_r  <= i_den;
            cnt_r  <= CW'(NW);
            busy_r <= 1'b1;
            done_r <= 1'b0;
        end else if (busy_r) begin
            rem_r  <= fits ? trial[DW-1:0] : shifted[DW-1:0];
            q_r    <= {q_r[NW-2:0], fits};
            cnt_r  <= cnt_r - 1'b1;
            busy_r <= (cnt_r != CW'(1));
            done_r <= (cnt_r == CW'(1));
        end else begin
            done_r <= 1'b0;
        end
    end

    assign o_done = done_r;
    assign o_quot = q_r;
    assign o_rem  = rem_r;
endmodule

// [tb/fcdd_core_assertions.sv]
`timescale 1ns/100ps
module fcdd_core_assertions (
    input wire logic        i_mclk,        // Clock.
    input wire logic        i_rstn,        // Reset, active low.
    input wire logic [2:0]  i_copro_id,    // Own identity.
    input wire logic        i_instr_valid, // Instruction offered.
    input wire logic [31:0] i_instr,       // Instruction word.
    input wire logic        i_data_valid,  // Host word offered.
    input wire logic [31:0] i_data,        // Host word.
    input wire logic [4:0]  i_rd_addr,     // Read address.
    input wire logic        o_ready,       // Idle.
    input wire logic        o_data_ready,  // Waiting for a word.
    input wire logic        o_done,        // Result pulse.
    input wire logic        o_unknown,     // Foreign code pulse.
    input wire logic [63:0] o_result,      // Last result.
    input wire logic [63:0] o_rd_data      // Read data.
);
    logic id_hit;
    logic take;
    logic dec_ok;
    logic conv_any;
    logic div_reg;
    logic div_host;
    logic conv_pend_r;

    // Decode what an idle design must take this cycle.
    assign id_hit = i_instr_valid && i_instr[31:29] == i_copro_id;
    assign take = o_ready && id_hit;
    assign dec_ok = take && i_instr[24:21] == fcdd_pkg::OP_MINUS_ONE
                    && i_instr[6:0] == fcdd_pkg::LOW_TAIL_ZERO;
    assign conv_any = take && i_instr[24:21] == fcdd_pkg::OP_CONVERT
        && (i_instr[15:0] == fcdd_pkg::LOW_CONV_HOST
        || i_instr[15:0] == fcdd_pkg::LOW_CONV_MEM);
    assign div_reg = take && i_instr[15:9] == fcdd_pkg::TOP_DIV_REG
                     && i_instr[6:0] == fcdd_pkg::LOW_TAIL_ZERO;
    assign div_host = take && i_instr[15:9] == fcdd_pkg::TOP_DIV_HOST
                      && i_instr[7:0] == 8'h00;

    // Remember a conversion so its host word is told from a divide word.
    always_ff @(posedge i_mclk) begin
        if (!i_rstn) conv_pend_r <= 1'b0;
        else if (conv_any) conv_pend_r <= 1'b1;
        else if (o_done) conv_pend_r <= 1'b0;
    end

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rstn);

    a_dec_first_done: assert property (
        dec_ok && i_instr[15:9] == fcdd_pkg::TOP_DEC_FIRST
        |=> o_done && !o_unknown) else $error("first bank decrement late");
    a_dec_second_done: assert property (
        dec_ok && i_instr[15:9] == fcdd_pkg::TOP_DEC_SECOND
        |=> o_done && !o_unknown) else $error("second bank decrement late");
    a_conv_wants_word: assert property (
        conv_any |=> o_data_ready && !o_ready && !o_done)
        else $error("convert did not wait for its word");
    a_conv_word_done: assert property (
        conv_pend_r && o_data_ready && i_data_valid
        |=> !o_data_ready && !o_done ##1 o_done)
        else $error("convert result not two cycles after word");
    a_div_stays_busy: assert property (
        div_reg |=> !o_ready [*8]) else $error("divide left idle early");
    a_div_done_bound: assert property (
        div_reg |-> ##[100:200] o_done) else $error("divide never done");
    a_hostdiv_wants_word: assert property (
        div_host |=> o_data_ready && !o_done)
        else $error("host divide did not wait for words");
    a_foreign_ignored: assert property (
        o_ready && i_instr_valid && i_instr[31:29] != i_copro_id
        |=> o_ready && !o_unknown && !o_data_ready)
        else $error("foreign identity acted on");
    a_unknown_cause: assert property (
        o_unknown |-> $past(id_hit)) else $error("unknown without cause");
    a_result_holds: assert property (
        !o_done |-> $stable(o_result)) else $error("result moved silently");

    c_dec: cover property (dec_ok);
    c_conv: cover property (conv_any);
    c_hostdiv: cover property (div_host);
endmodule

bind fcdd_core fcdd_core_assertions u_chk (.i_mclk, .i_rstn, .i_copro_id,
    .i_instr_valid, .i_instr, .i_data_valid, .i_data, .i_rd_addr, .o_ready,
    .o_data_ready, .o_done, .o_unknown, .o_result, .o_rd_data);

// [tb/fcdd_host_model.sv]
`timescale 1ns/100ps
module fcdd_host_model (
    input  wire logic        i_mclk,       // Clock.
    input  wire logic        i_data_ready, // Device waits for a word.
    input  wire logic [1:0]  i_mode,       // 0 regs, 1 post-inc, 2 pre-dec.
    input  wire logic [3:0]  i_delay,      // Stall before each word.
    input  wire logic [31:0] i_word0,      // First register word.
    input  wire logic [31:0] i_word1,      // Second register word.
    input  wire logic        i_load,       // Load address register.
    input  wire logic [31:0] i_addr,       // Address to load.
    output logic             o_data_valid, // Word offered.
    output logic [31:0]      o_data,       // Word.
    output logic [31:0]      o_addr        // Host address register.
);
    logic [3:0]  wait_r = 4'h0;
    logic        taken_r = 1'b0;
    logic        idx_r = 1'b0;
    logic [31:0] a;

    // A word counts as taken at a rising edge with both sides high.
    always @(posedge i_mclk) taken_r <= o_data_valid && i_data_ready;

    // Words change only after a falling edge and hold until taken.
    initial o_data_valid = 1'b0;
    initial o_data = 32'h0000_0000;
    initial o_addr = 32'h0000_0000;
    always @(negedge i_mclk) begin
        if (i_load) begin
            o_addr <= i_addr;
            idx_r <= 1'b0;
        end
        if (o_data_valid && taken_r) begin
            o_data_valid <= 1'b0;
            o_data <= ~o_data; // A released bus must not look held.
            idx_r <= ~idx_r;
            wait_r <= 4'h0;
            if (i_mode == 2'd1) o_addr <= o_addr + 32'h0000_0020;
        end else if (i_data_ready && !o_data_valid) begin
            if (wait_r < i_delay) wait_r <= wait_r + 4'h1;
            else begin
                a = o_addr;
                if (i_mode == 2'd2) a = o_addr - 32'h0000_0020;
                o_addr <= a;
                o_data <= (i_mode == 2'd0) ? (idx_r ? i_word1 : i_word0)
                          : (a ^ 32'h8000_0003);
                o_data_valid <= 1'b1;
            end
        end
    end
endmodule

// [tb/tb.sv]
`timescale 1ns/100ps
module tb;
    localparam logic [2:0] ID = 3'h5;
    logic i_mclk = 0, i_rstn = 0, i_instr_valid = 0, ld = 0;
    logic [31:0] i_instr = 0, w0 = 0, w1 = 0, ad = 0, hd, haddr;
    logic [4:0] i_rd_addr = 0;
    logic [1:0] md = 0;
    logic [3:0] dl = 0;
    logic [63:0] o_result, o_rd_data;
    logic o_ready, o_data_ready, o_done, o_unknown, hv;
    int n_mismatch = 0, n_tests = 0;

    // Clock at 125 MHz.
    always #4 i_mclk = ~i_mclk;

    fcdd_core u_dut (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_copro_id(ID),
        .i_instr_valid(i_instr_valid), .i_instr(i_instr),
        .i_data_valid(hv), .i_data(hd), .i_rd_addr(i_rd_addr),
        .o_ready(o_ready), .o_data_ready(o_data_ready), .o_done(o_done),
        .o_unknown(o_unknown), .o_result(o_result), .o_rd_data(o_rd_data));
    fcdd_host_model u_host (.i_mclk(i_mclk), .i_data_ready(o_data_ready),
        .i_mode(md), .i_delay(dl), .i_word0(w0), .i_word1(w1), .i_load(ld),
        .i_addr(ad), .o_data_valid(hv), .o_data(hd), .o_addr(haddr));

    function automatic logic [31:0] mk(input logic [3:0] s,
        input logic [3:0] o, input logic [4:0] d, input logic [15:0] l);
        return {ID, s, o, d, l};
    endfunction

    // Integer to single with truncation, as the design converts.
    function automatic logic [31:0] i2s(input logic [31:0] x);
        logic [31:0] m;
        int p;
        m = x[31] ? -x : x;
        if (m == 0) return 32'h0000_0000;
        p = 31;
        while (!m[p]) p--;
        m = m << (31 - p);
        return {x[31], 8'(127 + p), m[30:8]};
    endfunction

    task automatic chk(input logic [63:0] got, input logic [63:0] exp,
        input string what);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: %s got %h", $time, what, got);
        end
    endtask

    task automatic issue(input logic [31:0] w);
        int k;
        k = 0;
        @(negedge i_mclk); // Let a previous valid drop for one edge first.
        while (o_ready !== 1'b1 && k < 300) begin
            @(negedge i_mclk);
            k++;
        end
        i_instr = w;
        i_instr_valid = 1;
        @(negedge i_mclk);
        i_instr_valid = 0;
    endtask

    task automatic run(input logic [31:0] w, input logic [63:0] exp);
        int k;
        issue(w);
        k = 0;
        while (o_done !== 1'b1 && k < 400) begin
            @(negedge i_mclk);
            k++;
        end
        chk({63'h0, o_done}, 64'h1, "done");
        chk(o_result, exp, "result");
    endtask

    task automatic rd(input logic [4:0] a, input logic [63:0] exp);
        i_rd_addr = a;
        @(negedge i_mclk);
        chk(o_rd_data, exp, "register");
    endtask

    task automatic host(input logic [1:0] m, input logic [3:0] d,
        input logic [31:0] a0, input logic [31:0] a1, input logic [31:0] a);
        md = m;
        dl = d;
        w0 = a0;
        w1 = a1;
        ad = a;
        ld = 1;
        @(negedge i_mclk);
        ld = 0;
    endtask

    // Host load, post-increment and pre-decrement conversions.
    task automatic t_convert;
        host(0, 0, 32'h0000_0007, 0, 0);
        run(mk(1, 4'h6, 5'h02, 16'h5F00), i2s(7));
        rd(5'h01, 64'h7);
        host(1, 2, 0, 0, 32'h0000_1000);
        run(mk(3, 4'h6, 5'h13, 16'h9F00), i2s(32'h8000_1003));
        chk(haddr, 32'h0000_1020, "post address");
        rd(5'h03, 64'h8000_1003);
        host(2, 0, 0, 0, 32'h0000_1000);
        run(mk(4, 4'h6, 5'h14, 16'h9F00), i2s(32'h8000_0FE3));
        chk(haddr, 32'h0000_0FE0, "pre address");
        rd(5'h04, 64'h8000_0FE3);
    endtask

    // Decrements in each format and from each bank.
    task automatic t_dec;
        run(mk(1, 4'hD, 5'h1D, 16'h0200), 64'h6);
        rd(5'h01, 64'h6);
        run(mk(2, 4'hD, 5'h10, 16'h0300), 64'h40C0_0000);
        run(mk(0, 4'hD, 5'h11, 16'h0700), 64'h40A0_0000);
        rd(5'h11, 64'h40A0_0000);
        run(mk(0, 4'hD, 5'h06, 16'h0380), fcdd_pkg::DBL_NEG_ONE);
    endtask

    // Host-load and register divides; no spare or scratch operand.
    task automatic t_div;
        host(0, 1, 32'h0000_0064, 32'h0000_0007, 0);
        run(mk(4, 4'h2, 5'h05, 16'h5200), 64'hE);
        rd(5'h04, 64'h64);
        rd(5'h12, 64'h7);
        rd(fcdd_pkg::TEMP_CODE, 64'h2);
        run(mk(2, 4'h1, 5'h07, 16'h1300), 64'h3FB3_3333);
        run(mk(1, 4'h2, 5'h08, 16'h1200), 64'h0);
        run(mk(6, 4'h0, 5'h09, 16'h1380), 64'hFFF0_0000_0000_0000);
        rd(fcdd_pkg::TEMP_CODE, 64'h6);
    endtask

    // Foreign identity is ignored; unsupported codes are flagged.
    task automatic t_refuse;
        issue({ID ^ 3'h1, 4'h1, 4'hD, 5'h1D, 16'h0200});
        chk({62'h0, o_done, o_unknown}, 64'h0, "foreign");
        rd(5'h01, 64'h6);
        issue(mk(4, 4'h2, 5'h05, 16'h5380));
        chk({63'h0, o_unknown}, 64'h1, "double host divide");
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // Main sequence after four cycles of reset.
    initial begin
        repeat (4) @(negedge i_mclk);
        i_rstn = 1;
        @(negedge i_mclk);
        t_convert;
        t_dec;
        t_div;
        t_refuse;
        tally_and_finish;
    end

    // Watchdog well beyond the several hundred cycles the tests need.
    initial begin
        #(8 * 20000);
        n_mismatch++;
        tally_and_finish;
    end
endmodule
